// File: test/request_agent.sv
`timescale 1ns/1ns
// Processor and inbound agents issuing one decode request at a time.
module request_agent (
    input wire i_clk_sys,
    input wire i_route_valid,
    input wire [3:0] i_route_target,
    output logic o_req_valid = 1'b0,
    output logic [35:0] o_req_addr = 36'h0,
    output logic o_req_write = 1'b0,
    output logic o_req_io = 1'b0,
    output logic o_req_inbound = 1'b0,
    output logic o_req_smm_code = 1'b0
);
    // Flags f are write, io, inbound and smm code fetch, high bit first.
    task issue(input logic [35:0] a, input logic [3:0] f, output logic [3:0] t);
        integer n;
        @(posedge i_clk_sys);
        o_req_valid <= 1'b1;
        o_req_addr <= a;
        {o_req_write, o_req_io, o_req_inbound, o_req_smm_code} <= f;
        @(posedge i_clk_sys);
        o_req_valid <= 1'b0;
        // Released address lines wander, so a stale address is never reused.
        o_req_addr <= ~a;
        n = 0;
        @(negedge i_clk_sys);
        while (i_route_valid !== 1'b1 && n < 4) begin
            @(negedge i_clk_sys);
            n = n + 1;
        end
        t = (n < 4) ? i_route_target : 4'hF;
    endtask
endmodule

// File: test/system_address_decoder_properties.sv
`timescale 1ns/1ns
`include "address_decoder_defines.vh"
module system_address_decoder_properties (
    input wire i_clk_sys,
    input wire i_reset_n,
    input wire i_hsel,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire [2:0] i_hsize,
    input wire i_hready,
    input wire o_hreadyout,
    input wire o_hresp,
    input wire i_req_valid,
    input wire [35:0] i_req_addr,
    input wire i_req_write,
    input wire i_req_io,
    input wire i_req_inbound,
    input wire o_route_valid,
    input wire [3:0] o_route_target
);
    wire mem = i_req_valid && !i_req_io;
    wire [35:0] a = i_req_addr;
    wire rd = i_hsel && i_htrans[1] && !i_hwrite && i_hready && i_hsize == 3'h2;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);
    AST_ROUTE_PULSE: assert property (i_req_valid |=> o_route_valid)
        else $error("route result missing after request");
    AST_NO_SPURIOUS: assert property (!i_req_valid |=> !o_route_valid)
        else $error("route result without request");
    AST_TARGET_HOLD: assert property (!i_req_valid |=> $stable(o_route_target))
        else $error("route target changed without request");
    AST_LOW_DRAM: assert property (mem && a <= `LOW_HI |=> o_route_target == `TGT_DRAM)
        else $error("low range not sent to memory");
    AST_MID_DRAM: assert property (mem && a >= `MID_LO && a <= `MID_HI
        |=> o_route_target == `TGT_DRAM)
        else $error("one to fifteen MB range not sent to memory");
    AST_HIGH_DRAM: assert property (mem && a >= `FOUR_GB |=> o_route_target == `TGT_DRAM)
        else $error("range above 4GB not sent to memory");
    AST_INTC_HUB: assert property (mem && !i_req_inbound && a >= `INTC_HUB_LO
        && a <= `INTC_HUB_HI |=> o_route_target == `TGT_HUB)
        else $error("hub interrupt window not sent to hub link");
    AST_MONO_IO: assert property (i_req_valid && i_req_io && !i_req_inbound
        && a[15:0] inside {16'h03B4, 16'h03B5, 16'h03B8, 16'h03B9, 16'h03BA, 16'h03BF}
        |=> o_route_target == `TGT_HUB)
        else $error("monochrome port not sent to hub link");
    AST_INB_VGA_ABORT: assert property (mem && i_req_inbound && a >= `VGA_LO
        && a <= `VGA_HI |=> o_route_target == `TGT_ABORT)
        else $error("inbound display range not aborted");
    AST_INB_EBIOS_WR: assert property (mem && i_req_inbound && i_req_write
        && a >= `EBIOS_LO && a <= `EBIOS_HI |=> o_route_target == `TGT_HUB)
        else $error("inbound shadow write not sent to hub link");
    AST_READ_WAIT: assert property (rd |=> !o_hreadyout ##1 o_hreadyout)
        else $error("read data phase not one wait");
    AST_OKAY: assert property (o_hresp == 1'b0)
        else $error("bus response not okay");
    cover property (mem && i_req_inbound);
    cover property (rd);
    cover property (o_route_valid && o_route_target == `TGT_TERM);
endmodule

// File: test/test_system_address_decoder.sv
`timescale 1ns/1ns
`include "address_decoder_defines.vh"
module test_system_address_decoder;
    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_hsel = 1'b0;
    logic [31:0] i_haddr = 32'h0;
    logic [1:0] i_htrans = 2'h0;
    logic i_hwrite = 1'b0;
    logic [2:0] i_hsize = 3'h2;
    logic [31:0] i_hwdata = 32'h0;
    wire o_hreadyout, o_hresp, rq_valid, rq_write, rq_io, rq_inb, rq_smm, o_route_valid;
    wire [31:0] o_hrdata;
    wire [35:0] rq_addr;
    wire [3:0] o_route_target;
    integer mismatches = 0;
    integer num_checks = 0;
    integer cycles = 0;
    integer k;
    logic [31:0] v;
    logic [3:0] t;
    logic [15:0] mono [0:5] = '{16'h03B4, 16'h03B5, 16'h03B8, 16'h03B9, 16'h03BA, 16'h03BF};

    always #10 i_clk_sys = ~i_clk_sys;

    system_address_decoder uut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_hsel(i_hsel),
        .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
        .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hreadyout(o_hreadyout),
        .o_hrdata(o_hrdata), .o_hresp(o_hresp), .i_req_valid(rq_valid), .i_req_addr(rq_addr),
        .i_req_write(rq_write), .i_req_io(rq_io), .i_req_inbound(rq_inb),
        .i_req_smm_code(rq_smm), .o_route_valid(o_route_valid),
        .o_route_target(o_route_target));

    request_agent agent (.i_clk_sys(i_clk_sys), .i_route_valid(o_route_valid),
        .i_route_target(o_route_target), .o_req_valid(rq_valid), .o_req_addr(rq_addr),
        .o_req_write(rq_write), .o_req_io(rq_io), .o_req_inbound(rq_inb),
        .o_req_smm_code(rq_smm));

    task finish_test;
        if (mismatches == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge i_clk_sys);
        i_hsel <= 1'b1;
        i_haddr <= {24'h0, a};
        i_htrans <= 2'h2;
        i_hwrite <= wr;
        i_hsize <= 3'h2;
        @(posedge i_clk_sys);
        while (o_hreadyout !== 1'b1) @(posedge i_clk_sys);
        i_htrans <= 2'h0;
        i_hwdata <= wd;
        @(posedge i_clk_sys);
        while (o_hreadyout !== 1'b1) @(posedge i_clk_sys);
        v = o_hrdata;
    endtask

    task rc(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        check("register", v, e);
    endtask

    task rt(input logic [35:0] a, input logic [3:0] f, input logic [3:0] e);
        agent.issue(a, f, t);
        check("route", {28'h0, t}, {28'h0, e});
    endtask

    always @(posedge i_clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches = mismatches + 1;
            finish_test;
        end
    end

    initial begin
        repeat (3) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        rc(`OFS_CTRL, 32'h002);
        rc(`OFS_SHADOW, 32'h0);
        rc(`OFS_LOWTOP, 32'h800);
        rc(`OFS_ECFG, 32'hE);
        ahb(1'b1, 8'h14, 32'hFFFF_FFFF);
        rc(8'h14, 32'h0);
        rt(36'h0, 4'h0, `TGT_DRAM);
        rt(36'h0009FFFF, 4'h8, `TGT_DRAM);
        rt(36'h00100000, 4'h0, `TGT_DRAM);
        rt(36'h00EFFFFF, 4'h2, `TGT_DRAM);
        rt(36'h7FFFFFFF, 4'h0, `TGT_DRAM);
        rt(36'h300000000, 4'h0, `TGT_DRAM);
        rt(36'h000A0000, 4'h0, `TGT_HUB);
        rt(36'h000BFFFF, 4'h8, `TGT_HUB);
        rt(36'h000F0000, 4'h0, `TGT_HUB);
        rt(36'h000F0000, 4'h8, `TGT_HUB);
        rt(36'hFEC80000, 4'h0, `TGT_HUB);
        rt(36'hE0000000, 4'h0, `TGT_CFG);
        rt(36'hEFFFFFFF, 4'h0, `TGT_CFG);
        rt(36'h80000000, 4'h0, `TGT_HUB);
        rt(36'h80000000, 4'h2, `TGT_TERM);
        rt(36'h000A0000, 4'h2, `TGT_ABORT);
        rt(36'h000E0000, 4'hA, `TGT_HUB);
        rt(36'h000EFFFF, 4'h2, `TGT_INTERNAL);
        for (k = 0; k < 6; k = k + 1) rt({20'h0, mono[k]}, 4'h4, `TGT_HUB);
        rt(36'h000003B6, 4'h4, `TGT_PASS);
        ahb(1'b1, `OFS_CTRL, 32'h008);
        rt(36'hFEC80FFF, 4'h0, `TGT_PEA);
        rt(36'hFEC81000, 4'h0, `TGT_PEA1);
        rt(36'hFEC82FFF, 4'h0, `TGT_PEB);
        rt(36'hFEC7FFFF, 4'h0, `TGT_HUB);
        rt(36'hFEC83000, 4'h0, `TGT_HUB);
        rt(36'h000BFFFF, 4'h0, `TGT_PEA);
        ahb(1'b1, `OFS_CTRL, 32'h00C);
        rt(36'h000B0000, 4'h0, `TGT_HUB);
        rt(36'h000B7FFF, 4'h8, `TGT_HUB);
        rt(36'h000B8000, 4'h0, `TGT_PEA);
        ahb(1'b1, `OFS_CTRL, 32'h010);
        rt(36'h000A0000, 4'h0, `TGT_PEA1);
        ahb(1'b1, `OFS_CTRL, 32'h0E4);
        rt(36'h000A0000, 4'h0, `TGT_DRAM);
        rt(36'h000B0000, 4'h0, `TGT_DRAM);
        ahb(1'b1, `OFS_CTRL, 32'h064);
        rt(36'h000A0000, 4'h0, `TGT_PEB);
        rt(36'h000B0000, 4'h1, `TGT_DRAM);
        ahb(1'b1, `OFS_CTRL, 32'h001);
        rt(36'h00F00000, 4'h0, `TGT_HUB);
        rt(36'h00FFFFFF, 4'h8, `TGT_HUB);
        rt(36'h01000000, 4'h0, `TGT_DRAM);
        ahb(1'b1, `OFS_CTRL, 32'h340);
        rt(36'h7FFE0000, 4'h0, `TGT_TERM);
        rt(36'h7FFE0000, 4'h1, `TGT_DRAM);
        rt(36'h7FFDFFFF, 4'h0, `TGT_DRAM);
        rt(36'h7FFFFFFF, 4'h2, `TGT_TERM);
        ahb(1'b0, `OFS_STATUS, 32'h0);
        check("status", v, 32'h0004_0006);
        ahb(1'b1, `OFS_CTRL, 32'hF40);
        rt(36'h7FF00000, 4'h8, `TGT_TERM);
        rt(36'h7FEFFFFF, 4'h0, `TGT_DRAM);
        ahb(1'b1, `OFS_CTRL, 32'hD40);
        rt(36'h7FF00000, 4'h0, `TGT_DRAM);
        ahb(1'b1, `OFS_CTRL, 32'h3C0);
        rt(36'h7FFE0000, 4'h0, `TGT_DRAM);
        ahb(1'b1, `OFS_SHADOW, 32'h2800001);
        rc(`OFS_SHADOW, 32'h2800001);
        rt(36'h000C0000, 4'h0, `TGT_DRAM);
        rt(36'h000C3FFF, 4'h8, `TGT_HUB);
        rt(36'h000C4000, 4'h0, `TGT_HUB);
        rt(36'h000EC000, 4'h8, `TGT_DRAM);
        rt(36'h000EC000, 4'h0, `TGT_HUB);
        rt(36'h000FFFFF, 4'h8, `TGT_DRAM);
        rt(36'h000F0000, 4'h0, `TGT_HUB);
        rt(36'h000E0000, 4'h2, `TGT_INTERNAL);
        ahb(1'b1, `OFS_ECFG, 32'hD);
        rt(36'hD0000000, 4'h0, `TGT_CFG);
        rt(36'hE0000000, 4'h0, `TGT_HUB);
        ahb(1'b1, `OFS_LOWTOP, 32'h400);
        rt(36'h40000000, 4'h0, `TGT_HUB);
        rt(36'h3FFFFFFF, 4'h0, `TGT_DRAM);
        finish_test;
    end
endmodule

bind system_address_decoder system_address_decoder_properties u_props (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_hsel(i_hsel), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hready(i_hready), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .i_req_valid(i_req_valid), .i_req_addr(i_req_addr),
    .i_req_write(i_req_write), .i_req_io(i_req_io), .i_req_inbound(i_req_inbound),
    .o_route_valid(o_route_valid), .o_route_target(o_route_target));

// File: verilog/address_decoder_defines.vh
`ifndef ADDRESS_DECODER_DEFINES_VH
`define ADDRESS_DECODER_DEFINES_VH

// Register byte offsets on the register bus.
`define OFS_CTRL 8'h00
`define OFS_SHADOW 8'h04
`define OFS_LOWTOP 8'h08
`define OFS_ECFG 8'h0C
`define OFS_STATUS 8'h10

// Control register fields.
`define CTRL_ISA_HOLE 0
`define CTRL_INTC_DIS 1
`define CTRL_MONO_HUB 2
`define CTRL_VGA_A 3
`define CTRL_VGA_A1 4
`define CTRL_VGA_B 5
`define CTRL_SMM_GLOBAL 6
`define CTRL_SMM_OPEN 7
`define CTRL_TOP_SMM_SEGMENT_EN 8
`define CTRL_HSMM_EN 9
`define CTRL_SEGMENT_SIZE_FIELD_LO 10
`define CTRL_WIDTH 12

// Reset values.
`define RST_CTRL 12'h002
`define RST_SHADOW 26'h0000000
`define RST_LOWTOP 12'h800
`define RST_ECFG 4'hE

// Fixed address ranges.
`define LOW_HI 36'h0_0009_FFFF
`define VGA_LO 36'h0_000A_0000
`define VGA_HI 36'h0_000B_FFFF
`define MDA_LO 36'h0_000B_0000
`define MDA_HI 36'h0_000B_7FFF
`define SHD_LO 36'h0_000C_0000
`define SHD_HI 36'h0_000F_FFFF
`define EBIOS_LO 36'h0_000E_0000
`define EBIOS_HI 36'h0_000E_FFFF
`define MID_LO 36'h0_0010_0000
`define MID_HI 36'h0_00EF_FFFF
`define HOLE_LO 36'h0_00F0_0000
`define HOLE_HI 36'h0_00FF_FFFF
`define MAIN_LO 36'h0_0100_0000
`define FOUR_GB 36'h1_0000_0000
`define TOP_SMM_SEGMENT_MIN 36'h0_0002_0000
`define INTC_HUB_LO 36'h0_FEC0_0000
`define INTC_HUB_HI 36'h0_FEC7_FFFF
`define INTC_PORT_A 20'hFEC80
`define INTC_PORT_A1 20'hFEC81
`define INTC_PORT_HI 20'hFEC82

// Route target codes.
`define TGT_DRAM 4'h0
`define TGT_HUB 4'h1
`define TGT_PEA 4'h2
`define TGT_PEA1 4'h3
`define TGT_PEB 4'h4
`define TGT_CFG 4'h5
`define TGT_TERM 4'h6
`define TGT_ABORT 4'h7
`define TGT_INTERNAL 4'h8
`define TGT_PASS 4'h9

`endif

// File: verilog/ahb_reg_port.v
`timescale 1ns/1ns
// AHB-Lite slave front end: writes take no wait, reads take one wait.
module ahb_reg_port (
    input wire i_clk_sys,
    input wire i_reset_n,
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire [2:0] i_hsize,
    input wire i_hready,
    input wire [31:0] i_rdata,
    output wire o_wr_en,
    output wire [7:0] o_addr,
    output reg o_hreadyout,
    output reg [31:0] o_hrdata,
    output reg o_hresp
);
    reg dp_valid_q;
    reg dp_write_q;
    reg [7:0] dp_addr_q;
    wire take;

    assign take = i_hsel & i_htrans[1] & i_hready & (i_hsize == 3'h2);
    assign o_wr_en = dp_valid_q & dp_write_q & o_hreadyout;
    assign o_addr = dp_addr_q;

    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_addr_q <= 8'h00;
            o_hreadyout <= 1'b1;
            o_hrdata <= 32'h0000_0000;
            o_hresp <= 1'b0;
        end else if (o_hreadyout) begin
            dp_valid_q <= take;
            if (take) begin
                dp_write_q <= i_hwrite;
                dp_addr_q <= {i_haddr[7:2], 2'h0};
            end
            if (take && !i_hwrite) begin
                o_hreadyout <= 1'b0;
            end
        end else begin
            o_hrdata <= i_rdata;
            o_hreadyout <= 1'b1;
        end
    end
endmodule

// File: verilog/shadow_segment_lookup.v
`timescale 1ns/1ns
// Picks the read and write attribute of one shadow segment.
module shadow_segment_lookup #(
    parameter SEGS = 13
) (
    input wire [3:0] i_seg,
    input wire [2*SEGS-1:0] i_attr,
    output reg o_read_en,
    output reg o_write_en
);
    localparam [3:0] LAST_SEG = SEGS - 1;
    reg [3:0] idx;
    integer k;

    always @* begin
        idx = (i_seg > LAST_SEG) ? LAST_SEG : i_seg;
        o_read_en = 1'b0;
        o_write_en = 1'b0;
        for (k = 0; k < SEGS; k = k + 1) begin
            if (idx == k) begin
                o_read_en = i_attr[2*k];
                o_write_en = i_attr[2*k+1];
            end
        end
    end
endmodule

// File: verilog/system_address_decoder.v
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
`include "address_decoder_defines.vh"

module system_address_decoder #(
    parameter SHADOW_SEGS = 13
) (
    input wire i_clk_sys,
    input wire i_reset_n,
    input wire i_hsel,
    input wire [31:0] i_haddr,
    input wire [1:0] i_htrans,
    input wire i_hwrite,
    input wire [2:0] i_hsize,
    input wire [31:0] i_hwdata,
    input wire i_hready,
    output wire o_hreadyout,
    output wire [31:0] o_hrdata,
    output wire o_hresp,
    input wire i_req_valid,
    input wire [35:0] i_req_addr,
    input wire i_req_write,
    input wire i_req_io,
    input wire i_req_inbound,
    input wire i_req_smm_code,
    output reg o_route_valid,
    output reg [3:0] o_route_target
);
    reg [`CTRL_WIDTH-1:0] ctrl_q;
    reg [2*SHADOW_SEGS-1:0] shadow_q;
    reg [11:0] lowtop_q;
    reg [3:0] ecfg_q;
    reg [3:0] last_target_q;
    reg [15:0] refused_count_q;
    reg [31:0] rdata;
    reg [3:0] target_d;
    wire wr_en;
    wire [7:0] reg_addr;
    wire seg_read_en;
    wire seg_write_en;
    wire [35:0] a;
    wire [35:0] low_memory_top;
    wire [35:0] top_smm_segment_base;
    wire smm_ok;
    wire top_smm_segment_active;
    wire [1:0] segment_size_field;

    function in_rng;
        input [35:0] x;
        input [35:0] lo;
        input [35:0] hi;
        begin
            in_rng = (x >= lo) && (x <= hi);
        end
    endfunction

    function is_mono_port;
        input [15:0] p;
        begin
            case (p)
                16'h03B4, 16'h03B5, 16'h03B8, 16'h03B9, 16'h03BA, 16'h03BF: begin
                    is_mono_port = 1'b1;
                end
                default: begin
                    is_mono_port = 1'b0;
                end
            endcase
        end
    endfunction

    // Maps a 4KB interrupt window above the hub window to its port.
    function [3:0] intc_port_target;
        input [35:0] x;
        begin
            case (x[31:12])
                `INTC_PORT_A: begin
                    intc_port_target = `TGT_PEA;
                end
                `INTC_PORT_A1: begin
                    intc_port_target = `TGT_PEA1;
                end
                `INTC_PORT_HI: begin
                    intc_port_target = `TGT_PEB;
                end
                default: begin
                    intc_port_target = `TGT_HUB;
                end
            endcase
        end
    endfunction

    ahb_reg_port u_port (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_hsel(i_hsel),
        .i_haddr(i_haddr),
        .i_htrans(i_htrans),
        .i_hwrite(i_hwrite),
        .i_hsize(i_hsize),
        .i_hready(i_hready),
        .i_rdata(rdata),
        .o_wr_en(wr_en),
        .o_addr(reg_addr),
        .o_hreadyout(o_hreadyout),
        .o_hrdata(o_hrdata),
        .o_hresp(o_hresp)
    );

    shadow_segment_lookup #(
        .SEGS(SHADOW_SEGS)
    ) u_lookup (
        .i_seg(a[17:14]),
        .i_attr(shadow_q),
        .o_read_en(seg_read_en),
        .o_write_en(seg_write_en)
    );

    assign a = i_req_addr;
    assign low_memory_top = {4'h0, lowtop_q, 20'h00000};
    assign segment_size_field = ctrl_q[`CTRL_SEGMENT_SIZE_FIELD_LO+1:`CTRL_SEGMENT_SIZE_FIELD_LO];
    assign top_smm_segment_base = low_memory_top - (`TOP_SMM_SEGMENT_MIN << segment_size_field);
    assign smm_ok = ctrl_q[`CTRL_SMM_GLOBAL] & ~i_req_inbound &
        (ctrl_q[`CTRL_SMM_OPEN] | i_req_smm_code);
    assign top_smm_segment_active = ctrl_q[`CTRL_HSMM_EN] & ctrl_q[`CTRL_TOP_SMM_SEGMENT_EN];

    always @* begin
        case (reg_addr)
            `OFS_CTRL: begin
                rdata = {{(32-`CTRL_WIDTH){1'b0}}, ctrl_q};
            end
            `OFS_SHADOW: begin
                rdata = {{(32-2*SHADOW_SEGS){1'b0}}, shadow_q};
            end
            `OFS_LOWTOP: begin
                rdata = {20'h00000, lowtop_q};
            end
            `OFS_ECFG: begin
                rdata = {28'h0000000, ecfg_q};
            end
            `OFS_STATUS: begin
                rdata = {refused_count_q, 12'h000, last_target_q};
            end
            default: begin
                rdata = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_q <= `RST_CTRL;
            shadow_q <= `RST_SHADOW;
            lowtop_q <= `RST_LOWTOP;
            ecfg_q <= `RST_ECFG;
        end else if (wr_en) begin
            case (reg_addr)
                `OFS_CTRL: begin
                    ctrl_q <= i_hwdata[`CTRL_WIDTH-1:0];
                end
                `OFS_SHADOW: begin
                    shadow_q <= i_hwdata[2*SHADOW_SEGS-1:0];
                end
                `OFS_LOWTOP: begin
                    lowtop_q <= i_hwdata[11:0];
                end
                `OFS_ECFG: begin
                    ecfg_q <= i_hwdata[3:0];
                end
                default: begin
                    ctrl_q <= ctrl_q;
                end
            endcase
        end
    end

    always @* begin
        target_d = `TGT_HUB;
        if (i_req_io) begin
            if (i_req_inbound) begin
                target_d = `TGT_ABORT;
            end else if (is_mono_port(a[15:0])) begin
                target_d = `TGT_HUB;
            end else begin
                target_d = `TGT_PASS;
            end
        end else if (a <= `LOW_HI) begin
            target_d = `TGT_DRAM;
        end else if (in_rng(a, `VGA_LO, `VGA_HI)) begin
            if (i_req_inbound) begin
                target_d = `TGT_ABORT;
            end else if (smm_ok) begin
                target_d = `TGT_DRAM;
            end else if (ctrl_q[`CTRL_MONO_HUB] && in_rng(a, `MDA_LO, `MDA_HI)) begin
                target_d = `TGT_HUB;
            end else if (ctrl_q[`CTRL_VGA_A]) begin
                target_d = `TGT_PEA;
            end else if (ctrl_q[`CTRL_VGA_A1]) begin
                target_d = `TGT_PEA1;
            end else if (ctrl_q[`CTRL_VGA_B]) begin
                target_d = `TGT_PEB;
            end else begin
                target_d = `TGT_HUB;
            end
        end else if (in_rng(a, `SHD_LO, `SHD_HI)) begin
            if (i_req_inbound) begin
                if (!in_rng(a, `EBIOS_LO, `EBIOS_HI)) begin
                    target_d = `TGT_ABORT;
                end else if (i_req_write) begin
                    target_d = `TGT_HUB;
                end else begin
                    target_d = `TGT_INTERNAL;
                end
            end else if (i_req_write ? seg_write_en : seg_read_en) begin
                target_d = `TGT_DRAM;
            end else begin
                target_d = `TGT_HUB;
            end
        end else if (in_rng(a, `MID_LO, `MID_HI)) begin
            target_d = `TGT_DRAM;
        end else if (in_rng(a, `HOLE_LO, `HOLE_HI)) begin
            target_d = ctrl_q[`CTRL_ISA_HOLE] ? `TGT_HUB : `TGT_DRAM;
        end else if (a < low_memory_top) begin
            if (a >= top_smm_segment_base && top_smm_segment_active) begin
                if (ctrl_q[`CTRL_SMM_GLOBAL] && smm_ok) begin
                    target_d = `TGT_DRAM;
                end else begin
                    target_d = `TGT_TERM;
                end
            end else begin
                target_d = `TGT_DRAM;
            end
        end else if (a < `FOUR_GB) begin
            if (i_req_inbound) begin
                target_d = `TGT_TERM;
            end else if (a[35:28] == {4'h0, ecfg_q}) begin
                target_d = `TGT_CFG;
            end else if (in_rng(a, `INTC_HUB_LO, `INTC_HUB_HI)) begin
                target_d = `TGT_HUB;
            end else if (ctrl_q[`CTRL_INTC_DIS]) begin
                target_d = `TGT_HUB;
            end else begin
                target_d = intc_port_target(a);
            end
        end else begin
            target_d = `TGT_DRAM;
        end
    end

    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_route_valid <= 1'b0;
            o_route_target <= `TGT_HUB;
            last_target_q <= `TGT_HUB;
            refused_count_q <= 16'h0000;
        end else begin
            o_route_valid <= i_req_valid;
            if (i_req_valid) begin
                o_route_target <= target_d;
                last_target_q <= target_d;
                if (target_d == `TGT_TERM || target_d == `TGT_ABORT) begin
                    refused_count_q <= refused_count_q + 16'h0001;
                end
            end
        end
    end
endmodule
